/* File: lbc_mac_model.sv */
module lbc_mac_model
(
    input  wire logic  core_clk,
    input  wire logic  rst,
    output logic [4:0] mac_tx_sym
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------
    // mac transmit stream
    // ----------
    // changes every cycle and wraps every 32 cycles, so a stale symbol on the line matches it only once in 32 cycles
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            mac_tx_sym <= 5'h00;
        else
            mac_tx_sym <= mac_tx_sym + 5'h01;
    end
endmodule : lbc_mac_model

/* File: lbc_pkg.sv */
package lbc_pkg;

    // ------------------------------------------------------------
    // register placement and field layout
    // ------------------------------------------------------------
    localparam logic [4:0]  LBC_REG_ADDR        = 5'h18;
    localparam int          LBC_BAD_SSD_BIT     = 15;
    localparam int          LBC_CODING_BP_BIT   = 14;
    localparam int          LBC_SCR_BP_BIT      = 13;
    localparam int          LBC_ALIGN_BP_BIT    = 12;
    localparam int          LBC_TEN_LPBK_BIT    = 11;
    localparam int          LBC_LB_SEL_LSB      = 8;
    localparam logic        LBC_BAD_SSD_RST     = 1'b1;
    localparam logic        LBC_TEN_LPBK_RST    = 1'b0;
    localparam logic [1:0]  LBC_LB_SEL_RST      = 2'h0;

    // ------------------------------------------------------------
    // receive error code and idle count
    // ------------------------------------------------------------
    localparam logic [3:0]  LBC_BAD_SSD_CODE    = 4'he;
    localparam logic [1:0]  LBC_IDLE_NEEDED     = 2'h2;

    // ------------------------------------------------------------
    // loopback dead time
    // ------------------------------------------------------------
    localparam int          LBC_CLK_MHZ         = 250;
    localparam int          LBC_DEAD_TIME_US    = 550;
    localparam int          LBC_DEAD_CYCLES     = LBC_DEAD_TIME_US * LBC_CLK_MHZ;
    localparam int          LBC_DEAD_CNT_W      = 18;

    typedef enum logic [1:0]
    {
        LBC_LB_NORMAL   = 2'b00,
        LBC_LB_EXTERNAL = 2'b01,
        LBC_LB_REMOTE   = 2'b10,
        LBC_LB_RESERVED = 2'b11
    } lbc_lb_mode_t;

    typedef enum logic [0:0]
    {
        LBC_RX_PASS = 1'b0,
        LBC_RX_BAD  = 1'b1
    } lbc_rx_state_t;

    // one received symbol as seen by the mac: nibble plus error (fifth bit in transparent mode)
    typedef struct packed
    {
        logic [3:0] data;
        logic       er;
    } lbc_rx_sym_t;

endpackage : lbc_pkg

/* File: lbc_rx_err.sv */
module lbc_rx_err
(
    input  wire logic                core_clk,
    input  wire logic                rst,
    input  wire logic                ce,
    input  wire logic                detect_en,
    input  wire logic                align_bypass,
    input  wire logic                sym_valid,
    input  wire logic                bad_ssd,
    input  wire logic                idle_group,
    input  wire logic                crs_in,
    input  wire lbc_pkg::lbc_rx_sym_t sym_in,
    output lbc_pkg::lbc_rx_sym_t     sym_out,
    output logic                     crs_out
);
    import lbc_pkg::*;

    lbc_rx_state_t state_reg;
    lbc_rx_state_t state_next;
    logic [1:0]    idle_cnt_reg;

    // ------------------------------------------------------------
    // bad delimiter state
    // ------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            LBC_RX_PASS:
                if (sym_valid && bad_ssd && detect_en && !align_bypass)
                    state_next = LBC_RX_BAD;
            LBC_RX_BAD:
                if (align_bypass)
                    state_next = LBC_RX_PASS;
                else if (sym_valid && idle_group && idle_cnt_reg == LBC_IDLE_NEEDED - 2'h1)
                    state_next = LBC_RX_PASS;
            default:
                state_next = LBC_RX_PASS;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            state_reg <= LBC_RX_PASS;
        else if (ce)
            state_reg <= state_next;
    end

    // consecutive idle groups seen while in the error state
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            idle_cnt_reg <= 2'h0;
        else if (ce)
        begin
            if (state_reg != LBC_RX_BAD)
                idle_cnt_reg <= 2'h0;
            else if (sym_valid)
                idle_cnt_reg <= idle_group ? idle_cnt_reg + 2'h1 : 2'h0;
        end
    end

    // ------------------------------------------------------------
    // output stage
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            sym_out <= '0;
            crs_out <= 1'b0;
        end
        else if (ce)
        begin
            if (state_next == LBC_RX_BAD)
            begin
                // er doubles as the fifth bit, giving 11110 in transparent mode
                sym_out.data <= LBC_BAD_SSD_CODE;
                sym_out.er   <= 1'b1;
                crs_out      <= 1'b1;
            end
            // alignment bypass hands the stream back untouched at once
            else if (state_reg == LBC_RX_BAD && !align_bypass)
            begin
                sym_out <= '0;
                crs_out <= 1'b0;
            end
            else
            begin
                sym_out <= sym_in;
                crs_out <= crs_in;
            end
        end
    end

endmodule : lbc_rx_err

/* File: lbc_top.sv */
// Operation
// - bit 15 resets to one and enables bad start delimiter detection
// - bad delimiter forces error high and nibble 1110 until two consecutive idles
// - two consecutive idle groups after a bad delimiter drop error and carrier sense
// - in transparent mode the five-bit value shown is 11110
// - alignment bypass leaves receive data and error untouched
// - bits 14 to 12 load strap levels on the first enabled edge after reset, then software writable
// - bit 14 bypasses four-to-five encoding and decoding
// - bit 13 bypasses scrambler and descrambler
// - bit 12 bypasses descramble, alignment, decode, encode and scramble
// - bit 11 resets to zero and enables manchester codec loopback
// - bits 9:8 reset to 00 select normal, external, remote, reserved
// - remote loopback returns line data to transmit and mii, ignores mac
// - entering external loopback gives 550 us dead time on data outputs
// - internal loopback in the basic control register overrides bits 9:8
module lbc_top
#(
    parameter int DEAD_CYCLES = lbc_pkg::LBC_DEAD_CYCLES
)
(
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    input  wire logic                 ce,
    input  wire logic                 coding_bypass_strap,
    input  wire logic                 scrambler_bypass_strap,
    input  wire logic                 alignment_bypass_strap,
    input  wire logic                 reg_wr_en,
    input  wire logic                 reg_rd_en,
    input  wire logic [4:0]           reg_addr,
    input  wire logic [15:0]          reg_wr_data,
    output logic [15:0]               reg_rd_data,
    input  wire logic                 basic_control_reg_loopback,
    input  wire logic                 rx_sym_valid,
    input  wire logic                 rx_bad_ssd,
    input  wire logic                 rx_idle_group,
    input  wire logic                 rx_crs_in,
    input  wire lbc_pkg::lbc_rx_sym_t rx_sym_in,
    output lbc_pkg::lbc_rx_sym_t      rx_sym_out,
    output logic                      rx_crs_out,
    output logic                      rx_data_valid,
    input  wire logic [4:0]           mac_tx_sym,
    input  wire logic [4:0]           line_rx_sym,
    output logic [4:0]                tx_line_pair_sym,
    output logic                      tx_line_pair_valid,
    output logic                      coding_bypass,
    output logic                      scrambler_bypass,
    output logic                      alignment_bypass,
    output logic                      ten_meg_codec_loopback,
    output lbc_pkg::lbc_lb_mode_t     loopback_mode
);
    import lbc_pkg::*;

    logic                      bad_delimiter_detect_en;
    logic [1:0]                hundred_meg_loopback_sel;
    logic                      strap_pending_reg;
    logic                      reg_wr_hit;
    logic                      reg_rd_hit;
    logic                      mode_enter_ext;
    lbc_lb_mode_t              mode_next;
    logic [LBC_DEAD_CNT_W-1:0] dead_cnt_reg;
    logic                      dead_active;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic logic reg_hit(input logic [4:0] addr);
        return addr == LBC_REG_ADDR;
    endfunction : reg_hit

    assign reg_wr_hit     = reg_wr_en && reg_hit(reg_addr);
    assign reg_rd_hit     = reg_rd_en && reg_hit(reg_addr);
    // only the edge into external mode starts the dead time, staying there does not
    assign mode_enter_ext = mode_next == LBC_LB_EXTERNAL && loopback_mode != LBC_LB_EXTERNAL;
    assign dead_active    = dead_cnt_reg != '0;

    // ------------------------------------------------------------
    // register bits
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            bad_delimiter_detect_en  <= LBC_BAD_SSD_RST;
            ten_meg_codec_loopback   <= LBC_TEN_LPBK_RST;
            hundred_meg_loopback_sel <= LBC_LB_SEL_RST;
        end
        else if (ce && reg_wr_hit)
        begin
            bad_delimiter_detect_en  <= reg_wr_data[LBC_BAD_SSD_BIT];
            ten_meg_codec_loopback   <= reg_wr_data[LBC_TEN_LPBK_BIT];
            hundred_meg_loopback_sel <= reg_wr_data[LBC_LB_SEL_LSB +: 2];
        end
    end

    // strap levels are caught on the first enabled edge after reset release
    // and win over a register write that lands on that same edge
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            strap_pending_reg <= 1'b1;
        else if (ce)
            strap_pending_reg <= 1'b0;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            coding_bypass    <= 1'b0;
            scrambler_bypass <= 1'b0;
            alignment_bypass <= 1'b0;
        end
        else if (ce && strap_pending_reg)
        begin
            coding_bypass    <= coding_bypass_strap;
            scrambler_bypass <= scrambler_bypass_strap;
            alignment_bypass <= alignment_bypass_strap;
        end
        else if (ce && reg_wr_hit)
        begin
            coding_bypass    <= reg_wr_data[LBC_CODING_BP_BIT];
            scrambler_bypass <= reg_wr_data[LBC_SCR_BP_BIT];
            alignment_bypass <= reg_wr_data[LBC_ALIGN_BP_BIT];
        end
    end

    // reserved bit 10 and the low byte read as zero
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            reg_rd_data <= 16'h0000;
        else if (ce)
        begin
            reg_rd_data <= 16'h0000;
            if (reg_rd_hit)
            begin
                reg_rd_data[LBC_BAD_SSD_BIT]      <= bad_delimiter_detect_en;
                reg_rd_data[LBC_CODING_BP_BIT]    <= coding_bypass;
                reg_rd_data[LBC_SCR_BP_BIT]       <= scrambler_bypass;
                reg_rd_data[LBC_ALIGN_BP_BIT]     <= alignment_bypass;
                reg_rd_data[LBC_TEN_LPBK_BIT]     <= ten_meg_codec_loopback;
                reg_rd_data[LBC_LB_SEL_LSB +: 2]  <= hundred_meg_loopback_sel;
            end
        end
    end

    // ------------------------------------------------------------
    // loopback mode and dead time
    // ------------------------------------------------------------
    always_comb
    begin
        // internal loopback wins: field is masked to normal while it is set
        if (basic_control_reg_loopback)
            mode_next = LBC_LB_NORMAL;
        else
            mode_next = lbc_lb_mode_t'(hundred_meg_loopback_sel);
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            loopback_mode <= LBC_LB_NORMAL;
        else if (ce)
            loopback_mode <= mode_next;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            dead_cnt_reg <= '0;
        else if (ce)
        begin
            if (mode_enter_ext)
                dead_cnt_reg <= LBC_DEAD_CNT_W'(DEAD_CYCLES);
            else if (dead_active)
                dead_cnt_reg <= dead_cnt_reg - LBC_DEAD_CNT_W'(1);
        end
    end

    // ------------------------------------------------------------
    // transmit selection
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            tx_line_pair_sym   <= 5'h00;
            tx_line_pair_valid <= 1'b0;
            rx_data_valid      <= 1'b0;
        end
        else if (ce)
        begin
            if (loopback_mode == LBC_LB_REMOTE)
                tx_line_pair_sym <= line_rx_sym;
            else
                tx_line_pair_sym <= mac_tx_sym;
            tx_line_pair_valid <= !dead_active;
            rx_data_valid      <= !dead_active;
        end
    end

    // ------------------------------------------------------------
    // receive error handling
    // ------------------------------------------------------------
    lbc_rx_err u_rx_err
    (
        .core_clk     (core_clk),
        .rst          (rst),
        .ce           (ce),
        .detect_en    (bad_delimiter_detect_en),
        .align_bypass (alignment_bypass),
        .sym_valid    (rx_sym_valid),
        .bad_ssd      (rx_bad_ssd),
        .idle_group   (rx_idle_group),
        .crs_in       (rx_crs_in),
        .sym_in       (rx_sym_in),
        .sym_out      (rx_sym_out),
        .crs_out      (rx_crs_out)
    );

endmodule : lbc_top

/* File: lbc_top_props.sv */
module lbc_top_props
#(
    parameter int DEAD_CYCLES = 20
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wr_data,
    input wire logic [15:0] reg_rd_data,
    input wire logic basic_control_reg_loopback,
    input wire logic rx_sym_valid,
    input wire logic rx_bad_ssd,
    input wire logic rx_idle_group,
    input wire lbc_pkg::lbc_rx_sym_t rx_sym_in,
    input wire lbc_pkg::lbc_rx_sym_t rx_sym_out,
    input wire logic rx_crs_out,
    input wire logic rx_data_valid,
    input wire logic [4:0] line_rx_sym,
    input wire logic [4:0] tx_line_pair_sym,
    input wire logic coding_bypass,
    input wire logic scrambler_bypass,
    input wire logic alignment_bypass,
    input wire logic ten_meg_codec_loopback,
    input wire lbc_pkg::lbc_lb_mode_t loopback_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    import lbc_pkg::*;
    // ----------
    // shadow state and properties
    // ----------
    logic       det_reg;
    logic       idle_reg;
    logic [3:0] wr_bits;
    logic [4:0] rd_bits;
    assign wr_bits = reg_wr_data[14:11];
    assign rd_bits = {det_reg, coding_bypass, scrambler_bypass, alignment_bypass, ten_meg_codec_loopback};
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            det_reg <= LBC_BAD_SSD_RST;
        else if (ce && reg_wr_en && reg_addr == LBC_REG_ADDR)
            det_reg <= reg_wr_data[LBC_BAD_SSD_BIT];
    end
    // last valid symbol was an idle group
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            idle_reg <= 1'b0;
        else if (ce && rx_sym_valid)
            idle_reg <= rx_idle_group;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    a_bad_err_code : assert property (ce && rx_sym_valid && rx_bad_ssd && det_reg && !alignment_bypass
        |=> rx_sym_out.data == LBC_BAD_SSD_CODE && rx_sym_out.er && rx_crs_out) else $error("bad delimiter not flagged");
    a_idle_release : assert property (ce && rx_sym_valid && rx_idle_group && idle_reg && !alignment_bypass
        && rx_sym_out.er && rx_sym_out.data == LBC_BAD_SSD_CODE |=> !rx_sym_out.er && !rx_crs_out) else $error("no release");
    a_align_pass : assert property (ce && alignment_bypass |=> rx_sym_out == $past(rx_sym_in))
        else $error("bypassed symbol modified");
    a_remote_loop : assert property ((ce && loopback_mode == LBC_LB_REMOTE) ##1 loopback_mode == LBC_LB_REMOTE
        |-> tx_line_pair_sym == $past(line_rx_sym)) else $error("remote loop not sending line data");
    a_bcr_override : assert property (ce && basic_control_reg_loopback ##1 ce && basic_control_reg_loopback
        |-> loopback_mode == LBC_LB_NORMAL) else $error("internal loopback did not override");
    a_dead_quiet : assert property (ce && DEAD_CYCLES > 8 && loopback_mode == LBC_LB_EXTERNAL
        && $past(loopback_mode) != LBC_LB_EXTERNAL |-> ##1 (!rx_data_valid)[*8]) else $error("no dead time");
    a_reg_write : assert property (ce && reg_wr_en && reg_addr == LBC_REG_ADDR && !$past(rst)
        |=> {coding_bypass, scrambler_bypass, alignment_bypass, ten_meg_codec_loopback} == $past(wr_bits))
        else $error("written bits not applied");
    a_read_fields : assert property (ce && reg_rd_en && reg_addr == LBC_REG_ADDR |=> reg_rd_data[15:11] == $past(rd_bits)
        && reg_rd_data[10] == 1'b0 && reg_rd_data[7:0] == 8'h00) else $error("read fields wrong");
    c_bad_seen : cover property (rx_sym_out.er && rx_crs_out);
    c_remote : cover property (loopback_mode == LBC_LB_REMOTE);
    c_dead : cover property ($fell(rx_data_valid));
endmodule : lbc_top_props

bind lbc_top lbc_top_props #(.DEAD_CYCLES(DEAD_CYCLES)) props_u
(
    .core_clk, .rst, .ce, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data, .reg_rd_data, .basic_control_reg_loopback,
    .rx_sym_valid, .rx_bad_ssd, .rx_idle_group, .rx_sym_in, .rx_sym_out, .rx_crs_out, .rx_data_valid, .line_rx_sym,
    .tx_line_pair_sym, .coding_bypass, .scrambler_bypass, .alignment_bypass, .ten_meg_codec_loopback, .loopback_mode
);

/* File: lbc_top_test.sv */
module lbc_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    import lbc_pkg::*;
    localparam int DEAD = 20;
    logic core_clk, rst, ce, cs_strap, ss_strap, as_strap, wr_en, rd_en, bcr_lb, sv, bad, idle, crs;
    logic crs_out, dvalid, tvalid, cb, sb, ab, tl;
    logic [4:0] addr, mac_sym, line_sym, tx_sym;
    logic [15:0] wdata, rdata;
    lbc_rx_sym_t sin, sout;
    lbc_lb_mode_t mode;
    int failures, n_checks, cnt, lows;
    lbc_top #(.DEAD_CYCLES(DEAD)) dut_u
    (
        .core_clk(core_clk), .rst(rst), .ce(ce), .coding_bypass_strap(cs_strap), .scrambler_bypass_strap(ss_strap),
        .alignment_bypass_strap(as_strap), .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr),
        .reg_wr_data(wdata), .reg_rd_data(rdata), .basic_control_reg_loopback(bcr_lb), .rx_sym_valid(sv),
        .rx_bad_ssd(bad), .rx_idle_group(idle), .rx_crs_in(crs), .rx_sym_in(sin), .rx_sym_out(sout),
        .rx_crs_out(crs_out), .rx_data_valid(dvalid), .mac_tx_sym(mac_sym), .line_rx_sym(line_sym),
        .tx_line_pair_sym(tx_sym), .tx_line_pair_valid(tvalid), .coding_bypass(cb), .scrambler_bypass(sb),
        .alignment_bypass(ab), .ten_meg_codec_loopback(tl), .loopback_mode(mode)
    );
    lbc_mac_model mac_u (.core_clk(core_clk), .rst(rst), .mac_tx_sym(mac_sym));
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge core_clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge core_clk);
        wr_en <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        @(posedge core_clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1;
        chk("read data", exp, rdata);
    endtask : rd
    // one received symbol; exp is the five-bit value seen by the mac
    task automatic sym(input logic b, input logic i, input logic [3:0] d, input logic [4:0] exp, input logic c);
        @(posedge core_clk);
        sv <= 1'b1;
        bad <= b;
        idle <= i;
        sin <= '{d, 1'b0};
        @(posedge core_clk);
        sv <= 1'b0;
        #1;
        chk("rx symbol", {11'h000, exp}, {11'h000, sout.er, sout.data});
        chk("carrier", {15'h0000, c}, {15'h0000, crs_out});
    endtask : sym
    task automatic tx_chk(input logic rem);
        logic [4:0] m;
        @(posedge core_clk);
        #1;
        m = rem ? line_sym : mac_sym;
        @(posedge core_clk);
        #1;
        chk("line tx symbol", {11'h000, m}, {11'h000, tx_sym});
    endtask : tx_chk
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run
    initial
    begin
        failures = 0;
        n_checks = 0;
        {rst, ce, cs_strap, ss_strap, as_strap} = 5'b11101;
        {wr_en, rd_en, bcr_lb, sv, bad, idle, crs} = 7'h01;
        addr = 5'h00;
        wdata = 16'h0000;
        sin = '0;
        line_sym = 5'h15;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        repeat (3) @(posedge core_clk);
        rd(LBC_REG_ADDR, 16'hd000);
        chk("strap bypass", 16'h0005, {13'h0000, cb, sb, ab});
        $display("test reset done");
        wr(LBC_REG_ADDR, 16'h7a00);
        chk("bypass levels", 16'h000f, {12'h000, cb, sb, ab, tl});
        rd(LBC_REG_ADDR, 16'h7a00);
        wr(5'h19, 16'h0000);
        rd(5'h19, 16'h0000);
        // a write while the clock enable is low must not land
        @(posedge core_clk);
        ce <= 1'b0;
        wr(LBC_REG_ADDR, 16'h0000);
        chk("frozen bits", 16'h000f, {12'h000, cb, sb, ab, tl});
        @(posedge core_clk);
        ce <= 1'b1;
        rd(LBC_REG_ADDR, 16'h7a00);
        $display("test registers done");
        chk("remote mode", {14'h0000, LBC_LB_REMOTE}, {14'h0000, mode});
        tx_chk(1'b1);
        @(posedge core_clk);
        bcr_lb <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        chk("override mode", {14'h0000, LBC_LB_NORMAL}, {14'h0000, mode});
        tx_chk(1'b0);
        @(posedge core_clk);
        bcr_lb <= 1'b0;
        repeat (2) @(posedge core_clk);
        wr(LBC_REG_ADDR, 16'h0100);
        // both valid outputs must drop and then come back
        cnt = 0;
        lows = 0;
        while (cnt < 100 && !(lows > 0 && dvalid && tvalid))
        begin
            @(posedge core_clk);
            #1;
            cnt++;
            if (!dvalid && !tvalid)
                lows++;
        end
        chk("dead time", 16'h0001, {15'h0000, lows >= DEAD - 1 && lows <= DEAD + 2});
        if (cnt == 100)
        begin
            failures++;
            complete_run();
        end
        $display("test loopback modes done");
        wr(LBC_REG_ADDR, 16'h8000);
        sym(1'b1, 1'b0, 4'h5, 5'h1e, 1'b1);
        sym(1'b0, 1'b0, 4'h3, 5'h1e, 1'b1);
        sym(1'b0, 1'b1, 4'h0, 5'h1e, 1'b1);
        sym(1'b0, 1'b0, 4'h3, 5'h1e, 1'b1);
        sym(1'b0, 1'b1, 4'h0, 5'h1e, 1'b1);
        sym(1'b0, 1'b1, 4'h0, 5'h00, 1'b0);
        sym(1'b0, 1'b0, 4'h9, 5'h09, 1'b1);
        wr(LBC_REG_ADDR, 16'h0000);
        sym(1'b1, 1'b0, 4'h5, 5'h05, 1'b1);
        wr(LBC_REG_ADDR, 16'h8000);
        sym(1'b1, 1'b0, 4'h5, 5'h1e, 1'b1);
        // alignment bypass switched on in the error state releases the stream at once
        wr(LBC_REG_ADDR, 16'h9000);
        sym(1'b0, 1'b0, 4'h7, 5'h07, 1'b1);
        sym(1'b1, 1'b0, 4'h5, 5'h05, 1'b1);
        $display("test bad delimiter done");
        complete_run();
    end
endmodule : lbc_top_test
